// ---- rtl/intc_consts.svh ----
// Offsets, field positions, reset values of the interrupt and timer block
// Assumes a 32-bit APB with one aligned word per register
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

`define IDX_ENABLE 8'h04
`define IDX_FLAGS 8'h05
`define IDX_MODE 8'h06
`define IDX_COUNT_LOW 8'h07
`define IDX_COUNT_HIGH 8'h08
`define ADDR_ENABLE 12'h010
`define ADDR_FLAGS 12'h014
`define ADDR_MODE 12'h018
`define ADDR_COUNT_LOW 12'h01C
`define ADDR_COUNT_HIGH 12'h020

`define BIT_THIRD_TIMER 7
`define BIT_SECOND_TIMER 6
`define BIT_TOUCH_OVERFLOW 5
`define BIT_COMPARATOR 4
`define BIT_TOUCH_DONE 3
`define BIT_SIXTEEN_BIT_TIMER 2
`define BIT_RESERVED 1
`define BIT_EXT_PIN 0
`define SOURCE_MASK 8'hFD

`define ENABLE_RESET 8'h00
`define FLAGS_RESET 8'h00
`define MODE_RESET 8'h00
`define COUNT_RESET 16'h0000

`define CLKSRC_MSB 7
`define CLKSRC_LSB 5
`define PRESCALE_MSB 4
`define PRESCALE_LSB 3
`define EVSEL_MSB 2
`define EVSEL_LSB 0
`define EVSEL_BASE_BIT 8

`endif

// ---- rtl/intc_pkg.sv ----
// Types shared by the interrupt and timer block
// Assumes intc_consts.svh for numeric constants
package intc_pkg;

  typedef enum logic [2:0] {
    CLK_OFF = 3'b000,
    CLK_SYSTEM = 3'b001,
    CLK_RSVD_A = 3'b010,
    CLK_PIN_FOUR = 3'b011,
    CLK_FAST_OSC = 3'b100,
    CLK_RSVD_B = 3'b101,
    CLK_SLOW_OSC = 3'b110,
    CLK_PIN_ZERO = 3'b111
  } clock_source_t;

  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_4 = 2'b01,
    DIV_16 = 2'b10,
    DIV_64 = 2'b11
  } prescale_t;

  typedef struct packed {
    clock_source_t clock_source;
    prescale_t prescale;
    logic [2:0] event_select;
  } timer_mode_t;

  typedef struct packed {
    logic third_timer;
    logic second_timer;
    logic touch_count_overflow;
    logic comparator;
    logic touch_conversion_done;
    logic ext_pin;
  } source_events_t;

endpackage : intc_pkg

// ---- rtl/interrupt_and_sixteen_bit_timer_mode.sv ----
// Interrupt enable and pending flags plus sixteen-bit timer mode control
// Assumes APB master on ref_clk; source strobes are one-cycle, same clock
`timescale 1ns/100ps
`include "intc_consts.svh"

module interrupt_and_sixteen_bit_timer_mode #(
  parameter int COUNT_WIDTH = 16,
  parameter int PRESCALE_WIDTH = 6
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire intc_pkg::source_events_t source_events,
  input wire logic port_a_pin_zero,
  input wire logic port_a_pin_four,
  input wire logic fast_internal_oscillator,
  input wire logic slow_internal_oscillator,
  output logic irq_request
);

  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  intc_pkg::timer_mode_t mode_reg;
  intc_pkg::timer_mode_t mode_next;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [PRESCALE_WIDTH-1:0] prescale_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic watched_bit_reg;
  logic [3:0] sync_a_reg;
  logic [3:0] sync_b_reg;
  logic [3:0] sync_prev_reg;
  logic [3:0] fall_edge;
  logic [3:0] rise_edge;
  logic [3:0] raw_inputs;
  logic raw_tick;
  logic divided_tick;
  logic watched_bit;
  logic timer_event;
  logic [7:0] hw_set;
  logic setup_phase;
  logic access_phase;
  logic write_strobe;
  logic addr_valid;

  // Register decode
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == `ADDR_ENABLE) || (addr == `ADDR_FLAGS) ||
      (addr == `ADDR_MODE) || (addr == `ADDR_COUNT_LOW) ||
      (addr == `ADDR_COUNT_HIGH);
  endfunction : is_mapped

  // Prescaler terminal mask per divide code
  function automatic logic [PRESCALE_WIDTH-1:0] prescale_mask(
    input intc_pkg::prescale_t code);
    prescale_mask = PRESCALE_WIDTH'((32'h0000_0001 << (2 * int'(code))) -
      32'h0000_0001);
  endfunction : prescale_mask

  // APB phases
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_valid = is_mapped(paddr);
  assign write_strobe = access_phase && pwrite && addr_valid;
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_valid;
  assign prdata = prdata_reg;
  assign irq_request = irq_reg;

  // Pin and oscillator synchronisers, two stages each
  assign raw_inputs = {slow_internal_oscillator, fast_internal_oscillator,
    port_a_pin_four, port_a_pin_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_a_reg[gi] <= 1'b0;
          sync_b_reg[gi] <= 1'b0;
          sync_prev_reg[gi] <= 1'b0;
        end
        else
        begin
          sync_a_reg[gi] <= raw_inputs[gi];
          sync_b_reg[gi] <= sync_a_reg[gi];
          sync_prev_reg[gi] <= sync_b_reg[gi];
        end
      end
      assign fall_edge[gi] = sync_prev_reg[gi] && !sync_b_reg[gi];
      assign rise_edge[gi] = !sync_prev_reg[gi] && sync_b_reg[gi];
    end
  endgenerate

  // Timer clock source select
  always_comb
  begin
    case (mode_reg.clock_source)
      intc_pkg::CLK_SYSTEM: raw_tick = 1'b1;
      intc_pkg::CLK_PIN_FOUR: raw_tick = fall_edge[1];
      intc_pkg::CLK_FAST_OSC: raw_tick = rise_edge[2];
      intc_pkg::CLK_SLOW_OSC: raw_tick = rise_edge[3];
      intc_pkg::CLK_PIN_ZERO: raw_tick = fall_edge[0];
      default: raw_tick = 1'b0;
    endcase
  end

  // Prescaler
  assign divided_tick = raw_tick &&
    ((prescale_reg & prescale_mask(mode_reg.prescale)) ==
    prescale_mask(mode_reg.prescale));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_reg <= '0;
    end
    else if (mode_reg.clock_source == intc_pkg::CLK_OFF)
    begin
      prescale_reg <= '0;
    end
    else if (raw_tick)
    begin
      prescale_reg <= prescale_reg + PRESCALE_WIDTH'(1);
    end
  end

  // Sixteen-bit counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= `COUNT_RESET;
    end
    else if (divided_tick)
    begin
      count_reg <= count_reg + COUNT_WIDTH'(1);
    end
  end

  // Watched counter bit and change detect
  assign watched_bit =
    count_reg[`EVSEL_BASE_BIT + int'(mode_reg.event_select)];
  assign timer_event = watched_bit != watched_bit_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watched_bit_reg <= 1'b0;
    end
    else
    begin
      watched_bit_reg <= watched_bit;
    end
  end

  // Hardware set vector
  always_comb
  begin
    hw_set = 8'h00;
    hw_set[`BIT_THIRD_TIMER] = source_events.third_timer;
    hw_set[`BIT_SECOND_TIMER] = source_events.second_timer;
    hw_set[`BIT_TOUCH_OVERFLOW] = source_events.touch_count_overflow;
    hw_set[`BIT_COMPARATOR] = source_events.comparator;
    hw_set[`BIT_TOUCH_DONE] = source_events.touch_conversion_done;
    hw_set[`BIT_SIXTEEN_BIT_TIMER] = timer_event;
    hw_set[`BIT_EXT_PIN] = source_events.ext_pin;
  end

  // Enable register
  always_comb
  begin
    enable_next = enable_reg;
    if (write_strobe && paddr == `ADDR_ENABLE)
    begin
      enable_next = pwdata[7:0] & `SOURCE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_reg <= `ENABLE_RESET;
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  // Pending flags, set wins over clear
  always_comb
  begin
    flags_next = flags_reg;
    if (write_strobe && paddr == `ADDR_FLAGS)
    begin
      flags_next = pwdata[7:0];
    end
    flags_next = (flags_next | hw_set) & `SOURCE_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg <= `FLAGS_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  // Timer mode register
  always_comb
  begin
    mode_next = mode_reg;
    if (write_strobe && paddr == `ADDR_MODE)
    begin
      mode_next.clock_source = intc_pkg::clock_source_t'(
        pwdata[`CLKSRC_MSB:`CLKSRC_LSB]);
      mode_next.prescale = intc_pkg::prescale_t'(
        pwdata[`PRESCALE_MSB:`PRESCALE_LSB]);
      mode_next.event_select = pwdata[`EVSEL_MSB:`EVSEL_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= intc_pkg::timer_mode_t'(`MODE_RESET);
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  // Core request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(flags_reg & enable_reg);
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (setup_phase && !pwrite)
    begin
      case (paddr)
        `ADDR_ENABLE:
        begin
          prdata_reg <= {24'h00_0000, enable_reg};
        end
        `ADDR_FLAGS:
        begin
          prdata_reg <= {24'h00_0000, flags_reg};
        end
        `ADDR_MODE:
        begin
          prdata_reg <= {24'h00_0000, 8'(mode_reg)};
        end
        `ADDR_COUNT_LOW:
        begin
          prdata_reg <= {24'h00_0000, count_reg[7:0]};
        end
        `ADDR_COUNT_HIGH:
        begin
          prdata_reg <= {24'h00_0000, count_reg[15:8]};
        end
        default:
        begin
          prdata_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : interrupt_and_sixteen_bit_timer_mode

// ---- sim/intc_checker.sv ----
// Port assertions for the interrupt and timer mode block
// Assumes a bind onto interrupt_and_sixteen_bit_timer_mode
`timescale 1ns/100ps
module intc_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire intc_pkg::source_events_t source_events,
  input wire logic irq_request
);
  logic [7:0] en_reg;
  logic [7:0] ev;
  logic acc;
  logic rd;
  logic mapped;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign ev = {source_events[5:1], 2'h0, source_events[0]};
  assign mapped = paddr inside {12'h10, 12'h14, 12'h18, 12'h1C, 12'h20};
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_reg <= 8'h0;
    else if (acc && pwrite && paddr == 12'h10)
      en_reg <= pwdata[7:0] & 8'hFD;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_bit1_zero: assert property (
    rd && paddr inside {12'h10, 12'h14} |-> !prdata[1])
    else $error("reserved bit reads one");
  a_en_readback: assert property (
    rd && paddr == 12'h10 |-> prdata[7:0] == en_reg)
    else $error("enable readback wrong");
  a_irq_blocked: assert property (
    $past(en_reg) == 8'h0 |-> !irq_request)
    else $error("request with all sources disabled");
  a_ready_access: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_event_irq: assert property (
    (|ev) ##1 (|($past(ev) & en_reg)) |-> ##1 irq_request)
    else $error("enabled event gave no request");
  a_flag_read: assert property (
    psel && !penable && !pwrite && paddr == 12'h14
    |=> (prdata[7:0] & $past(ev, 2)) == $past(ev, 2))
    else $error("event flag not seen");
  c_irq: cover property (irq_request);
  c_err: cover property (acc && pslverr);
  c_timer: cover property (rd && paddr == 12'h14 && prdata[2]);
endmodule : intc_checker

// ---- sim/source_model.sv ----
// Event strobes, pins and oscillator inputs feeding the block
// Assumes ref_clk domain; kick bits become one-cycle strobes
`timescale 1ns/100ps
module source_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] kick,
  input wire logic run,
  output intc_pkg::source_events_t events,
  output logic pin_zero,
  output logic pin_four,
  output logic fast_osc,
  output logic slow_osc
);
  logic [4:0] phase_reg;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      events <= '0;
    else
      events <= kick;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_reg <= 5'h0;
    else if (run)
      phase_reg <= phase_reg + 5'h1;
  end
  assign pin_zero = phase_reg[2];
  assign fast_osc = phase_reg[2];
  assign pin_four = phase_reg[4];
  assign slow_osc = phase_reg[4];
endmodule : source_model

// ---- sim/testbench.sv ----
// Self-checking bench for the interrupt and timer mode block
// Assumes source_model and intc_checker are compiled first
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] kick = 6'h0;
  logic run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_request;
  logic pin_zero;
  logic pin_four;
  logic fast_osc;
  logic slow_osc;
  intc_pkg::source_events_t events;
  int fails = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  always #10 ref_clk = ~ref_clk;
  source_model model (.ref_clk(ref_clk), .rst_n(rst_n), .kick(kick),
    .run(run), .events(events), .pin_zero(pin_zero),
    .pin_four(pin_four), .fast_osc(fast_osc), .slow_osc(slow_osc));
  interrupt_and_sixteen_bit_timer_mode DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .source_events(events),
    .port_a_pin_zero(pin_zero), .port_a_pin_four(pin_four),
    .fast_internal_oscillator(fast_osc),
    .slow_internal_oscillator(slow_osc), .irq_request(irq_request));
  task conclude;
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task poke(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : poke
  task peek(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : peek
  task t_registers;
    peek(12'h10, 32'h0);
    peek(12'h14, 32'h0);
    peek(12'h18, 32'h0);
    poke(12'h10, 32'hFFFF_FFFF);
    peek(12'h10, 32'hFD);
    poke(12'h10, 32'h0);
    peek(12'h10, 32'h0);
    peek(12'h2C, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_registers
  task t_sources;
    logic [7:0] m;
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? 8'h1 : 8'h4 << i;
      @(posedge ref_clk);
      kick <= 6'h1 << i;
      @(posedge ref_clk);
      kick <= 6'h0;
      peek(12'h14, {24'h0, m});
      check({31'h0, irq_request}, 32'h0);
      poke(12'h10, {24'h0, m});
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq_request}, 32'h1);
      poke(12'h14, 32'h0);
      peek(12'h14, 32'h0);
      check({31'h0, irq_request}, 32'h0);
      @(posedge ref_clk);
      kick <= 6'h1 << i;
      @(posedge ref_clk);
      kick <= 6'h0;
      repeat (3) @(posedge ref_clk);
      check({31'h0, irq_request}, 32'h1);
      poke(12'h14, 32'h0);
      poke(12'h10, 32'h0);
    end
    poke(12'h14, 32'hFF);
    peek(12'h14, 32'hFD);
    poke(12'h14, 32'h0);
  endtask : t_sources
  task t_timer;
    logic [7:0] md [12];
    int span [12];
    md = '{8'h20, 8'h28, 8'h30, 8'h38, 8'h27, 8'h60, 8'hE0, 8'hC0,
      8'h80, 8'h0, 8'h40, 8'hA0};
    span = '{300, 1100, 4200, 16500, 32800, 8300, 2200, 8300, 2200,
      2200, 2200, 2200};
    run <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      poke(12'h18, {24'h0, md[i]});
      peek(12'h18, {24'h0, md[i]});
      poke(12'h14, 32'h0);
      repeat (span[i]) @(posedge ref_clk);
      peek(12'h14, (i < 9) ? 32'h4 : 32'h0);
    end
    poke(12'h18, 32'h0);
  endtask : t_timer
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_registers;
    t_sources;
    t_timer;
    conclude;
  end
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    fails++;
    conclude;
  end
endmodule : testbench
bind interrupt_and_sixteen_bit_timer_mode intc_checker chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr),
  .source_events(source_events), .irq_request(irq_request));
